// File: design/scf_params.svh
`ifndef SCF_PARAMS_SVH
`define SCF_PARAMS_SVH

// register byte offsets
`define SCF_A_MODE_LOW     8'h00
`define SCF_A_MODE_HIGH    8'h04
`define SCF_A_MODE_P4      8'h08
`define SCF_A_OSC_RELOAD   8'h0c
`define SCF_A_CLOCK_SETUP  8'h10
`define SCF_A_AUX          8'h14
`define SCF_A_AUX_TWO      8'h18
`define SCF_A_NV_CTRL      8'h1c
`define SCF_A_FUSE_STAT    8'h20
`define SCF_A_STATUS       8'h24

// field positions in software registers
`define SCF_B_TPS_HI       7
`define SCF_B_TPS_LO       4
`define SCF_B_X2           0
`define SCF_B_LATCH_SUPP   0
`define SCF_B_XDATA_EN     1
`define SCF_B_WS_HI        6
`define SCF_B_WS_LO        5
`define SCF_B_STACK_IN_EXTRA_RAM         4
`define SCF_B_BOOT_API     5
`define SCF_B_NV_EN        1

// fuse word layout
`define SCF_FUSE_W         17
`define SCF_F_SRC_A_HI     1
`define SCF_F_SRC_A_LO     0
`define SCF_F_SRC_B_HI     3
`define SCF_F_SRC_B_LO     2
`define SCF_F_OSC_B        4
`define SCF_F_X2           5
`define SCF_F_START_HI     8
`define SCF_F_START_LO     6
`define SCF_F_COMPAT       9
`define SCF_F_XRAM         10
`define SCF_F_BOOT_JUMP    11
`define SCF_F_DEBUG        12
`define SCF_F_ISP          13
`define SCF_F_SIG          14
`define SCF_F_TRISTATE     15
`define SCF_F_LOW_POWER    16

// reset values
`define SCF_TPS_FAST       4'h0
`define SCF_TPS_COMPAT     4'h5
`define SCF_RELOAD_RST     8'h00
`define SCF_SYNC_CYCLES    2'h2

`endif

// File: design/scf_pkg.sv
package scf_pkg;

  typedef enum logic [2:0] {
    SCF_ST_SYNC,
    SCF_ST_LATCH,
    SCF_ST_APPLY,
    SCF_ST_DELAY,
    SCF_ST_RUN
  } scf_state_t;

  // {pin_mode_high_bit, pin_mode_low_bit}
  typedef enum logic [1:0] {
    SCF_IO_QUASI     = 2'h0,
    SCF_IO_PUSH_PULL = 2'h1,
    SCF_IO_INPUT     = 2'h2,
    SCF_IO_OPEN_DRN  = 2'h3
  } scf_io_mode_t;

endpackage : scf_pkg

// File: design/scf_config.sv
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "scf_params.svh"
// Functional notes
// - fuse values persist; captured copy never altered
// - every reset restores software control defaults
// - two mode bits per pin, four modes
// - port-state fuse picks input-only or quasi
// - fuse sets clock doubling reset default
// - four-bit prescale field divides timer base
// - reload register sets oscillator-to-system ratio
// - aux bit0 suppresses address latch strobe
// - aux bit1 enables on-chip xdata, fuse default
// - aux bits6-5 insert xdata wait states
// - aux-two bit4 puts stack in extra RAM
// - nv data access only while enable set
// - boot API calls only while enable set
// - execution-mode fuse picks compat or fast
// - oscillator-select fuse picks boot oscillator
// - fuse picks oscillator A source
// - fuse picks oscillator B source
// - fuse-selected start-up delay after wake
// - in-system programming only with fuse set
// - signature programming only with fuse set
// - bootloader jump and low-power fuses applied
// - prescale resets 0000B fast, 0101B compat
// - divider resets to 1 fast, 2 compat without the X2 fuse, 1 compat with it
// - otherwise ports 1-3 quasi, port 0 open-drain
module scf_config
  import scf_pkg::*;
#(
  parameter int STARTUP_BASE_CYCLES = 16
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [`SCF_FUSE_W-1:0] fuse_array,
  output logic                        cpu_release,
  output logic                        fast_exec,
  output logic                        osc_b_select,
  output logic [1:0]                  osc_a_source,
  output logic [1:0]                  osc_b_source,
  output logic                        bootloader_enable,
  output logic                        low_power_enable,
  output logic [31:0]                 pin_mode_low_bit,
  output logic [31:0]                 pin_mode_high_bit,
  output logic [7:0]                  p4_mode_low_bit,
  output logic [7:0]                  p4_mode_high_bit,
  output logic [8:0]                  sysclk_divisor,
  output logic                        timer_tick,
  output logic                        latch_strobe_enable,
  output logic                        onchip_xdata_enable,
  output logic                        stack_in_extra_ram,
  input  wire logic                   xdata_req,
  output logic                        xdata_ack,
  input  wire logic                   nv_access_req,
  output logic                        nv_access_grant,
  input  wire logic                   boot_call_req,
  output logic                        boot_call_grant,
  input  wire logic                   debug_req,
  output logic                        debug_grant,
  input  wire logic                   isp_req,
  output logic                        isp_grant,
  input  wire logic                   sig_prog_req,
  output logic                        sig_prog_grant
);

  localparam int STARTUP_W = 24;

  scf_state_t               state_q;
  logic [1:0]               sync_cnt_q;
  logic [`SCF_FUSE_W-1:0]   fuse_s1_q;
  logic [`SCF_FUSE_W-1:0]   fuse_s2_q;
  logic [`SCF_FUSE_W-1:0]   fuse_q;
  logic [STARTUP_W-1:0]     start_cnt_q;
  logic [31:0]              mode_low_q;
  logic [31:0]              mode_high_q;
  logic [7:0]               p4_low_q;
  logic [7:0]               p4_high_q;
  logic [7:0]               reload_q;
  logic [3:0]               tps_q;
  logic                     x2_q;
  logic                     latch_supp_q;
  logic                     xdata_en_q;
  logic [1:0]               ws_q;
  logic                     stack_in_extra_ram_q;
  logic                     boot_api_q;
  logic                     nv_en_q;
  logic [3:0]               presc_cnt_q;
  logic [2:0]               ws_cnt_q;
  logic                     ws_busy_q;
  logic                     ph_write_q;
  logic [7:0]               ph_addr_q;
  logic [31:0]              rdata_q;
  logic                     addr_phase;
  logic                     fuse_fast;
  logic [STARTUP_W-1:0]     start_delay;

  // repeats one bit (hi or lo) of a pin mode pair over every pin of a port
  function automatic logic [7:0] scf_port_bits(input logic [1:0] mode, input logic hi);
    scf_port_bits = {8{hi ? mode[1] : mode[0]}};
  endfunction : scf_port_bits

  // reset mode of port 0..3 from the port-state fuse
  function automatic logic [1:0] scf_port_default(input logic tristate, input int port);
    if (tristate) begin
      scf_port_default = SCF_IO_INPUT;
    end else if (port == 0) begin
      scf_port_default = SCF_IO_OPEN_DRN;
    end else begin
      scf_port_default = SCF_IO_QUASI;
    end
  endfunction : scf_port_default

  function automatic logic [31:0] scf_mode_word(input logic tristate, input logic hi);
    logic [31:0] w;
    w = '0;
    for (int p = 0; p < 4; p++) begin
      w[p*8 +: 8] = scf_port_bits(scf_port_default(tristate, p), hi);
    end
    scf_mode_word = w;
  endfunction : scf_mode_word

  assign fuse_fast   = ~fuse_q[`SCF_F_COMPAT];
  assign start_delay = STARTUP_W'(STARTUP_BASE_CYCLES)
                       << fuse_q[`SCF_F_START_HI:`SCF_F_START_LO];
  assign addr_phase  = hsel & htrans[1] & hready;

  // fuse array is outside this clock, two stages before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_s1_q <= '0;
      fuse_s2_q <= '0;
    end else begin
      fuse_s1_q <= fuse_array;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  // boot sequence: sync, latch fuses, apply defaults, wait, run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= SCF_ST_SYNC;
      sync_cnt_q  <= '0;
      start_cnt_q <= '0;
    end else begin
      unique case (state_q)
        SCF_ST_SYNC: begin
          sync_cnt_q <= sync_cnt_q + 2'h1;
          if (sync_cnt_q == `SCF_SYNC_CYCLES) begin
            state_q <= SCF_ST_LATCH;
          end
        end
        SCF_ST_LATCH: state_q <= SCF_ST_APPLY;
        SCF_ST_APPLY: state_q <= SCF_ST_DELAY;
        SCF_ST_DELAY: begin
          start_cnt_q <= start_cnt_q + STARTUP_W'(1);
          if (start_cnt_q + STARTUP_W'(1) >= start_delay) begin
            state_q <= SCF_ST_RUN;
          end
        end
        SCF_ST_RUN: state_q <= SCF_ST_RUN;
      endcase
    end
  end

  // fuse image taken once per reset and then held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_q <= '0;
    end else if (state_q == SCF_ST_LATCH) begin
      fuse_q <= fuse_s2_q;
    end
  end

  assign cpu_release       = (state_q == SCF_ST_RUN);
  assign fast_exec         = fuse_fast;
  assign osc_b_select      = fuse_q[`SCF_F_OSC_B];
  assign osc_a_source      = fuse_q[`SCF_F_SRC_A_HI:`SCF_F_SRC_A_LO];
  assign osc_b_source      = fuse_q[`SCF_F_SRC_B_HI:`SCF_F_SRC_B_LO];
  assign bootloader_enable = fuse_q[`SCF_F_BOOT_JUMP];
  assign low_power_enable  = fuse_q[`SCF_F_LOW_POWER];

  // bus write in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write_q <= 1'b0;
      ph_addr_q  <= '0;
    end else if (hready) begin
      ph_write_q <= addr_phase & hwrite;
      ph_addr_q  <= haddr[7:0];
    end
  end

  // software control bits: defaults at apply, then writes only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_low_q  <= '0;
      mode_high_q <= '0;
      p4_low_q    <= '0;
      p4_high_q   <= '0;
    end else if (state_q == SCF_ST_APPLY) begin
      mode_low_q  <= scf_mode_word(fuse_q[`SCF_F_TRISTATE], 1'b0);
      mode_high_q <= scf_mode_word(fuse_q[`SCF_F_TRISTATE], 1'b1);
      p4_low_q    <= '0;
      p4_high_q   <= {8{fuse_q[`SCF_F_TRISTATE]}};
    end else if (ph_write_q) begin
      unique case (ph_addr_q)
        `SCF_A_MODE_LOW:  mode_low_q  <= hwdata;
        `SCF_A_MODE_HIGH: mode_high_q <= hwdata;
        `SCF_A_MODE_P4: begin
          p4_low_q  <= hwdata[7:0];
          p4_high_q <= hwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_q <= `SCF_RELOAD_RST;
      tps_q    <= `SCF_TPS_COMPAT;
      x2_q     <= 1'b0;
    end else if (state_q == SCF_ST_APPLY) begin
      reload_q <= `SCF_RELOAD_RST;
      tps_q    <= fuse_fast ? `SCF_TPS_FAST : `SCF_TPS_COMPAT;
      x2_q     <= fuse_fast | fuse_q[`SCF_F_X2];
    end else if (ph_write_q && ph_addr_q == `SCF_A_OSC_RELOAD) begin
      reload_q <= hwdata[7:0];
    end else if (ph_write_q && ph_addr_q == `SCF_A_CLOCK_SETUP) begin
      tps_q <= hwdata[`SCF_B_TPS_HI:`SCF_B_TPS_LO];
      x2_q  <= hwdata[`SCF_B_X2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_supp_q <= 1'b0;
      xdata_en_q   <= 1'b0;
      ws_q         <= '0;
      stack_in_extra_ram_q       <= 1'b0;
      boot_api_q   <= 1'b0;
      nv_en_q      <= 1'b0;
    end else if (state_q == SCF_ST_APPLY) begin
      latch_supp_q <= 1'b0;
      xdata_en_q   <= fuse_q[`SCF_F_XRAM];
      ws_q         <= '0;
      stack_in_extra_ram_q       <= 1'b0;
      boot_api_q   <= 1'b0;
      nv_en_q      <= 1'b0;
    end else if (ph_write_q) begin
      unique case (ph_addr_q)
        `SCF_A_AUX: begin
          latch_supp_q <= hwdata[`SCF_B_LATCH_SUPP];
          xdata_en_q   <= hwdata[`SCF_B_XDATA_EN];
          ws_q         <= hwdata[`SCF_B_WS_HI:`SCF_B_WS_LO];
        end
        `SCF_A_AUX_TWO: begin
          stack_in_extra_ram_q     <= hwdata[`SCF_B_STACK_IN_EXTRA_RAM];
          boot_api_q <= hwdata[`SCF_B_BOOT_API];
        end
        `SCF_A_NV_CTRL: nv_en_q <= hwdata[`SCF_B_NV_EN];
        default: ;
      endcase
    end
  end

  assign pin_mode_low_bit    = mode_low_q;
  assign pin_mode_high_bit   = mode_high_q;
  assign p4_mode_low_bit     = p4_low_q;
  assign p4_mode_high_bit    = p4_high_q;
  assign latch_strobe_enable = ~latch_supp_q;
  assign onchip_xdata_enable = xdata_en_q;
  assign stack_in_extra_ram  = stack_in_extra_ram_q;
  // x1 halves the source on top of the reload ratio
  assign sysclk_divisor = x2_q ? {1'b0, reload_q} + 9'h001
                               : {reload_q, 1'b0} + 9'h002;

  // timer base: one tick every tps+1 system clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_cnt_q <= '0;
    end else if (presc_cnt_q >= tps_q) begin
      presc_cnt_q <= '0;
    end else begin
      presc_cnt_q <= presc_cnt_q + 4'h1;
    end
  end
  assign timer_tick = cpu_release & (presc_cnt_q >= tps_q);

  // xdata access stretched by ws cycles; ack ends the access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ws_busy_q <= 1'b0;
      ws_cnt_q  <= '0;
    end else if (!ws_busy_q) begin
      ws_busy_q <= xdata_req;
      ws_cnt_q  <= {1'b0, ws_q};
    end else if (ws_cnt_q == 3'h0) begin
      ws_busy_q <= 1'b0;
    end else begin
      ws_cnt_q <= ws_cnt_q - 3'h1;
    end
  end
  assign xdata_ack = ws_busy_q & (ws_cnt_q == 3'h0);

  assign nv_access_grant = nv_access_req & nv_en_q & cpu_release;
  assign boot_call_grant = boot_call_req & boot_api_q & cpu_release;
  assign debug_grant     = debug_req & fuse_q[`SCF_F_DEBUG] & cpu_release;
  assign isp_grant       = isp_req & fuse_q[`SCF_F_ISP] & cpu_release;
  assign sig_prog_grant  = sig_prog_req & fuse_q[`SCF_F_SIG] & cpu_release;

  // read data registered at the address-phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        `SCF_A_MODE_LOW:    rdata_q <= mode_low_q;
        `SCF_A_MODE_HIGH:   rdata_q <= mode_high_q;
        `SCF_A_MODE_P4:     rdata_q <= {16'h0000, p4_high_q, p4_low_q};
        `SCF_A_OSC_RELOAD:  rdata_q <= {24'h000000, reload_q};
        `SCF_A_CLOCK_SETUP: rdata_q <= {24'h000000, tps_q, 3'h0, x2_q};
        `SCF_A_AUX:         rdata_q <= {25'h0, ws_q, 3'h0, xdata_en_q, latch_supp_q};
        `SCF_A_AUX_TWO:     rdata_q <= {26'h0, boot_api_q, stack_in_extra_ram_q, 4'h0};
        `SCF_A_NV_CTRL:     rdata_q <= {30'h0, nv_en_q, 1'b0};
        `SCF_A_FUSE_STAT:   rdata_q <= {15'h0000, fuse_q};
        `SCF_A_STATUS:      rdata_q <= {23'h0, sysclk_divisor};
        default:            rdata_q <= '0;
      endcase
    end
  end

  assign hrdata    = rdata_q;
  // bus held off until defaults are in place, so no write is lost
  assign hreadyout = cpu_release;
  assign hresp     = 1'b0;

  property p_tps_fast;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == SCF_ST_APPLY && fuse_fast) |=> tps_q == `SCF_TPS_FAST;
  endproperty
  a_tps_fast: assert property (p_tps_fast) else $error("fast prescale default wrong");

  property p_tps_compat;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == SCF_ST_APPLY && !fuse_fast) |=> tps_q == `SCF_TPS_COMPAT;
  endproperty
  a_tps_compat: assert property (p_tps_compat) else $error("compat prescale default wrong");

  property p_div_default;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == SCF_ST_APPLY && !fuse_q[`SCF_F_X2])
        |=> sysclk_divisor == (fuse_fast ? 9'h001 : 9'h002);
  endproperty
  a_div_default: assert property (p_div_default) else $error("divider default wrong");

  property p_port_default;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == SCF_ST_APPLY && !fuse_q[`SCF_F_TRISTATE])
        |=> mode_low_q == 32'h000000ff && mode_high_q == 32'h000000ff;
  endproperty
  a_port_default: assert property (p_port_default) else $error("port default wrong");

  property p_nv_gate;
    @(posedge hclk) disable iff (!hresetn)
      nv_access_grant |-> nv_en_q && nv_access_req;
  endproperty
  a_nv_gate: assert property (p_nv_gate) else $error("nv access without enable");

  property p_isp_gate;
    @(posedge hclk) disable iff (!hresetn)
      isp_grant |-> fuse_q[`SCF_F_ISP] && cpu_release;
  endproperty
  a_isp_gate: assert property (p_isp_gate) else $error("isp without fuse");

  property p_ws_three;
    @(posedge hclk) disable iff (!hresetn)
      (xdata_req && !ws_busy_q && ws_q == 2'h3) |-> !xdata_ack[*4] ##1 xdata_ack;
  endproperty
  a_ws_three: assert property (p_ws_three) else $error("wait state count wrong");

  property p_fuse_hold;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == SCF_ST_RUN) |=> $stable(fuse_q) && state_q == SCF_ST_RUN;
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("fuse image changed");

  property p_release_order;
    @(posedge hclk) disable iff (!hresetn)
      $rose(cpu_release) |-> $past(state_q) == SCF_ST_DELAY;
  endproperty
  a_release_order: assert property (p_release_order) else $error("cpu released early");

  property p_tick_full;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_release && tps_q == 4'h0 && $stable(tps_q)) |-> timer_tick;
  endproperty
  a_tick_full: assert property (p_tick_full) else $error("tick missing at full rate");

endmodule : scf_config

// File: test/tb.sv
`timescale 1ns/100ps
`include "scf_params.svh"
module tb;
  import scf_pkg::*;

  logic        hclk          = 1'b0;
  logic        hresetn       = 1'b0;
  logic        hsel          = 1'b0;
  logic [31:0] haddr         = 32'h0;
  logic [1:0]  htrans        = 2'h0;
  logic        hwrite        = 1'b0;
  logic [2:0]  hsize         = 3'h2;
  logic [31:0] hwdata        = 32'h0;
  logic        hready;
  logic [16:0] fuse_array    = 17'h0;
  logic        xdata_req     = 1'b0;
  logic        nv_access_req = 1'b0;
  logic        boot_call_req = 1'b0;
  logic        debug_req     = 1'b0;
  logic        isp_req       = 1'b0;
  logic        sig_prog_req  = 1'b0;
  logic [31:0] hrdata, pin_mode_low_bit, pin_mode_high_bit;
  logic        hreadyout, hresp, cpu_release, fast_exec, osc_b_select;
  logic [1:0]  osc_a_source, osc_b_source;
  logic        bootloader_enable, low_power_enable, timer_tick, latch_strobe_enable;
  logic [7:0]  p4_mode_low_bit, p4_mode_high_bit;
  logic [8:0]  sysclk_divisor;
  logic        onchip_xdata_enable, stack_in_extra_ram, xdata_ack, nv_access_grant;
  logic        boot_call_grant, debug_grant, isp_grant, sig_prog_grant;
  int          err_count     = 0;
  int          n_compared    = 0;
  int          cycles        = 0;
  int          c0, c1;

  // single slave, so its hreadyout is the bus ready
  assign hready = hreadyout;

  always #5 hclk = ~hclk;

  // short boot so the start-up delay stays a handful of cycles
  scf_config #(.STARTUP_BASE_CYCLES(1)) scf_config_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fuse_array(fuse_array),
    .cpu_release(cpu_release), .fast_exec(fast_exec), .osc_b_select(osc_b_select),
    .osc_a_source(osc_a_source), .osc_b_source(osc_b_source),
    .bootloader_enable(bootloader_enable), .low_power_enable(low_power_enable),
    .pin_mode_low_bit(pin_mode_low_bit), .pin_mode_high_bit(pin_mode_high_bit),
    .p4_mode_low_bit(p4_mode_low_bit), .p4_mode_high_bit(p4_mode_high_bit),
    .sysclk_divisor(sysclk_divisor), .timer_tick(timer_tick),
    .latch_strobe_enable(latch_strobe_enable), .onchip_xdata_enable(onchip_xdata_enable),
    .stack_in_extra_ram(stack_in_extra_ram), .xdata_req(xdata_req), .xdata_ack(xdata_ack),
    .nv_access_req(nv_access_req), .nv_access_grant(nv_access_grant),
    .boot_call_req(boot_call_req), .boot_call_grant(boot_call_grant),
    .debug_req(debug_req), .debug_grant(debug_grant), .isp_req(isp_req),
    .isp_grant(isp_grant), .sig_prog_req(sig_prog_req), .sig_prog_grant(sig_prog_grant)
  );

  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r, e);
    check(hresp, 1'b0);
  endtask : rchk

  // returns cycles from release to cpu start
  task automatic do_reset(input logic [16:0] f, output int n);
    hresetn    <= 1'b0;
    fuse_array <= f;
    repeat (3) @(posedge hclk);
    check({hreadyout, cpu_release, debug_grant, isp_grant}, 32'h0);
    hresetn <= 1'b1;
    n = 0;
    while (cpu_release !== 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    check(cpu_release, 1'b1);
  endtask : do_reset

  task automatic xdata_ws(input logic [1:0] w);
    int k, at, hits;
    wr(`SCF_A_AUX, {25'h0, w, 5'h0});
    xdata_req <= 1'b1;
    at = 0;
    hits = 0;
    for (k = 1; k <= 8; k++) begin
      @(posedge hclk);
      xdata_req <= 1'b0;
      #1;
      if (xdata_ack === 1'b1) begin
        at = k;
        hits++;
      end
    end
    check(at, w + 1);
    check(hits, 1);
    @(posedge hclk);
  endtask : xdata_ws

  task automatic tick_cnt(input logic [3:0] t);
    int n;
    wr(`SCF_A_CLOCK_SETUP, {24'h0, t, 4'h1});
    // let a stale count above the new limit clear to zero first
    repeat (16) @(posedge hclk);
    n = 0;
    repeat (48) begin
      @(posedge hclk);
      if (timer_tick === 1'b1) n++;
    end
    check(n, 48 / (t + 1));
  endtask : tick_cnt

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    do_reset(17'h1ac16, c0);
    check(pin_mode_high_bit, 32'hffffffff);
    check(pin_mode_low_bit, 32'h0);
    check({p4_mode_high_bit, p4_mode_low_bit}, 32'hff00);
    check(fast_exec, 1'b1);
    check(osc_b_select, 1'b1);
    check(osc_a_source, 2'h2);
    check(osc_b_source, 2'h1);
    check({bootloader_enable, low_power_enable}, 2'h3);
    check(sysclk_divisor, 9'h1);
    check({onchip_xdata_enable, latch_strobe_enable}, 2'h3);
    debug_req     <= 1'b1;
    isp_req       <= 1'b1;
    sig_prog_req  <= 1'b1;
    nv_access_req <= 1'b1;
    boot_call_req <= 1'b1;
    fuse_array    <= 17'h0;
    rchk(`SCF_A_CLOCK_SETUP, 32'h1);
    check({debug_grant, isp_grant, sig_prog_grant}, 3'h2);
    check({nv_access_grant, boot_call_grant}, 2'h0);
    check(osc_a_source, 2'h2);
    rchk(8'h30, 32'h0);
    wr(`SCF_A_AUX, 32'h21);
    wr(`SCF_A_AUX_TWO, 32'h30);
    wr(`SCF_A_NV_CTRL, 32'h2);
    wr(`SCF_A_OSC_RELOAD, 32'h3);
    wr(`SCF_A_MODE_LOW, 32'h0000ff00);
    wr(`SCF_A_MODE_HIGH, 32'h00ffff00);
    wr(`SCF_A_FUSE_STAT, 32'h0);
    @(posedge hclk);
    check({latch_strobe_enable, onchip_xdata_enable}, 2'h0);
    check(stack_in_extra_ram, 1'b1);
    check({nv_access_grant, boot_call_grant}, 2'h3);
    check(pin_mode_low_bit, 32'h0000ff00);
    check(pin_mode_high_bit, 32'h00ffff00);
    check(sysclk_divisor, 9'h4);
    rchk(`SCF_A_STATUS, 32'h4);
    rchk(`SCF_A_FUSE_STAT, 32'h1ac16);
    for (int w = 0; w < 4; w++) xdata_ws(2'(w));
    tick_cnt(4'h0);
    tick_cnt(4'h3);
    tick_cnt(4'hf);
    // mid-run reset into compatibility mode, ports not tristated
    do_reset(17'h01201, c0);
    check(pin_mode_low_bit, 32'hff);
    check(pin_mode_high_bit, 32'hff);
    check({p4_mode_high_bit, p4_mode_low_bit}, 32'h0);
    check(sysclk_divisor, 9'h2);
    check({fast_exec, debug_grant, isp_grant}, 3'h2);
    rchk(`SCF_A_CLOCK_SETUP, 32'h50);
    rchk(`SCF_A_AUX, 32'h0);
    rchk(`SCF_A_AUX_TWO, 32'h0);
    rchk(`SCF_A_NV_CTRL, 32'h0);
    rchk(`SCF_A_OSC_RELOAD, 32'h0);
    do_reset(17'h01221, c0);
    check(sysclk_divisor, 9'h1);
    rchk(`SCF_A_CLOCK_SETUP, 32'h51);
    do_reset(17'h012a1, c1);
    check(c1 - c0, 3);
    finish_test();
  end
endmodule : tb
